// *** psw_div.sv ***
// Programmable edge counter used for the main and reference dividers
`timescale 1ns/1ps
module psw_div #(
  parameter int W = 15
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  // Counting
  input wire logic edge_in,
  input wire logic [W-1:0] ratio_in,
  output logic tick_out,
  output logic half_out
);

  logic [W-1:0] cnt_ff;
  logic [W-1:0] cnt_inc;

  if (W < 2) begin : g_chk
    $error("psw_div: width too small");
  end

  assign cnt_inc = cnt_ff + {{(W-1){1'b0}}, 1'b1};

  // A ratio of zero behaves as one rather than stalling the loop
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt_ff <= '0;
      tick_out <= 1'b0;
    end else begin
      tick_out <= 1'b0;
      if (edge_in) begin
        if (cnt_inc >= ratio_in) begin
          cnt_ff <= '0;
          tick_out <= 1'b1;
        end else begin
          cnt_ff <= cnt_inc;
        end
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      half_out <= 1'b0;
    end else if (tick_out) begin
      half_out <= ~half_out;
    end
  end

endmodule

// *** psw_host.sv ***
// Bus controller model that drives the two-wire port
`timescale 1ns/1ps
module psw_host (
  // Clock
  input wire logic ref_clk_in,
  // Bus lines
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_low_out
);
  // Ref cycles per bus step, three steps to a bit, raised by the bench for a slow controller
  int q_len = 4;
  initial begin
    scl_out = 1'h1;
    sda_low_out = 1'h0;
  end
  task automatic step(input logic s, input logic l);
    @(posedge ref_clk_in);
    scl_out <= s;
    sda_low_out <= l;
    repeat (q_len - 1) @(posedge ref_clk_in);
  endtask
  // Also serves as repeated start
  task automatic send_start();
    step(1'h0, 1'h0);
    step(1'h1, 1'h0);
    step(1'h1, 1'h1);
    step(1'h0, 1'h1);
  endtask
  task automatic send_stop();
    step(1'h0, 1'h1);
    step(1'h1, 1'h1);
    step(1'h1, 1'h0);
  endtask
  // Data only moves while the clock is low, so no false start or stop
  task automatic put_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      step(1'h0, !b[i]);
      step(1'h1, !b[i]);
      step(1'h0, !b[i]);
    end
    step(1'h0, 1'h0);
    step(1'h1, 1'h0);
    ack = !sda_in;
    step(1'h0, 1'h0);
  endtask
endmodule

// *** psw_pkg.sv ***
// Shared constants and types for the synthesizer programming port
package psw_pkg;

  // ****************************************
  // Address byte layout
  // ****************************************
  localparam logic [4:0] ADDR_FIXED = 5'h18;
  localparam int ADDR_FIXED_MSB = 7;
  localparam int ADDR_FIXED_LSB = 3;
  localparam int ADDR_SEL_HI_POS = 2;
  localparam int ADDR_SEL_LO_POS = 1;
  localparam int ADDR_DIR_POS = 0;
  localparam logic ADDR_DIR_WRITE = 1'h0;

  // ****************************************
  // Data byte layout and auto-increment slots
  // ****************************************
  localparam int BYTE_W = 8;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam int SEL_BIT_POS = 7;
  localparam logic [1:0] SLOT_DIV_UPPER = 2'h0;
  localparam logic [1:0] SLOT_DIV_LOWER = 2'h1;
  localparam logic [1:0] SLOT_MODE_REF = 2'h2;
  localparam logic [1:0] SLOT_PUMP = 2'h3;
  localparam int DIV_W = 15;
  localparam int TEST_MSB = 6;
  localparam int TEST_LSB = 4;
  localparam int REFSEL_MSB = 3;
  localparam int REFSEL_LSB = 1;
  localparam int PUMP_MSB = 7;
  localparam int PUMP_LSB = 6;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [14:0] RST_DIV_RATIO = 15'h0001;
  localparam logic [2:0] RST_TEST_SEL = 3'h1;
  localparam logic [2:0] RST_REFDIV_SEL = 3'h0;
  localparam logic [1:0] RST_PUMP_SEL = 2'h0;

  // ****************************************
  // Test mode encodings
  // ****************************************
  localparam logic [2:0] TM_NORMAL_XOFF = 3'h0;
  localparam logic [2:0] TM_SINK_INIT = 3'h1;
  localparam logic [2:0] TM_HALF_DIV = 3'h2;
  localparam logic [2:0] TM_SINK = 3'h3;
  localparam logic [2:0] TM_NORMAL = 3'h4;
  localparam logic [2:0] TM_DBL_REF = 3'h5;
  localparam logic [2:0] TM_PUMP_OFF = 3'h6;
  localparam logic [2:0] TM_SOURCE = 3'h7;

  // ****************************************
  // Reference divider encodings and ratios
  // ****************************************
  localparam int REF_W = 6;
  localparam logic [2:0] RS_DIV2 = 3'h0;
  localparam logic [2:0] RS_DIV4 = 3'h1;
  localparam logic [2:0] RS_DIV8 = 3'h2;
  localparam logic [2:0] RS_DIV16 = 3'h5;
  localparam logic [2:0] RS_DIV32 = 3'h7;
  localparam logic [5:0] REF_RATIO_2 = 6'h02;
  localparam logic [5:0] REF_RATIO_4 = 6'h04;
  localparam logic [5:0] REF_RATIO_8 = 6'h08;
  localparam logic [5:0] REF_RATIO_16 = 6'h10;
  localparam logic [5:0] REF_RATIO_32 = 6'h20;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_FREQ_HZ = 20_000_000;
  localparam int CRYSTAL_FREQ_HZ = 4_000_000;
  localparam int CLK_PER_CRYSTAL = CLK_FREQ_HZ / CRYSTAL_FREQ_HZ;

  // ****************************************
  // Serial states, one-hot
  // ****************************************
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ADDR = 6'h02,
    ST_ADDR_ACK = 6'h04,
    ST_DATA = 6'h08,
    ST_DATA_ACK = 6'h10,
    ST_SKIP = 6'h20
  } psw_state_t;

  typedef struct packed {
    logic [2:0] test_sel;
    logic [2:0] refdiv_sel;
    logic [1:0] pump_sel;
  } psw_ctrl_t;

endpackage

// *** psw_top.sv ***
// Two-wire write port and divider/comparator datapath of the synthesizer
`timescale 1ns/1ps
module psw_top (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  // Two-wire bus
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  // Address select straps
  input wire logic addr_select_hi_in,
  input wire logic addr_select_lo_in,
  // Loop signals
  input wire logic vco_in,
  input wire logic crystal_in,
  // Charge pump, loop amplifier and crystal buffer
  output logic pump_up_out,
  output logic pump_dn_out,
  output logic [1:0] pump_current_out,
  output logic tuning_release_out,
  output logic crystal_buffer_out,
  // Programmed state
  output logic [14:0] divider_ratio_out,
  output logic [2:0] test_mode_out
);

  // ****************************************
  // Bus edge and condition detection
  // ****************************************
  logic scl_d_ff;
  logic sda_d_ff;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      scl_d_ff <= scl_in;
      sda_d_ff <= sda_in;
    end
  end

  assign scl_rise = scl_in & ~scl_d_ff;
  assign scl_fall = ~scl_in & scl_d_ff;
  assign start_cond = scl_in & scl_d_ff & sda_d_ff & ~sda_in;
  assign stop_cond = scl_in & scl_d_ff & ~sda_d_ff & sda_in;

  // ****************************************
  // Serial state machine
  // ****************************************
  psw_pkg::psw_state_t state_ff;
  logic [2:0] bit_cnt_ff;
  logic [6:0] shift_ff;
  logic ack_drive_ff;
  logic byte_done;
  logic [7:0] rx_byte;
  logic addr_match;

  assign byte_done = scl_rise && (bit_cnt_ff == psw_pkg::LAST_BIT);
  assign rx_byte = {shift_ff, sda_in};
  assign addr_match =
    (rx_byte[psw_pkg::ADDR_FIXED_MSB:psw_pkg::ADDR_FIXED_LSB] == psw_pkg::ADDR_FIXED) &&
    (rx_byte[psw_pkg::ADDR_SEL_HI_POS] == addr_select_hi_in) &&
    (rx_byte[psw_pkg::ADDR_SEL_LO_POS] == addr_select_lo_in) &&
    (rx_byte[psw_pkg::ADDR_DIR_POS] == psw_pkg::ADDR_DIR_WRITE);

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_ff <= psw_pkg::ST_IDLE;
    end else if (stop_cond) begin
      state_ff <= psw_pkg::ST_IDLE;
    end else if (start_cond) begin
      state_ff <= psw_pkg::ST_ADDR;
    end else begin
      case (state_ff)
        psw_pkg::ST_IDLE: state_ff <= psw_pkg::ST_IDLE;
        psw_pkg::ST_ADDR: begin
          if (byte_done) begin
            // Reads are not served here, so they are simply not acknowledged
            state_ff <= addr_match ? psw_pkg::ST_ADDR_ACK : psw_pkg::ST_SKIP;
          end
        end
        psw_pkg::ST_DATA: begin
          if (byte_done) begin
            state_ff <= psw_pkg::ST_DATA_ACK;
          end
        end
        psw_pkg::ST_ADDR_ACK, psw_pkg::ST_DATA_ACK: begin
          if (scl_fall && ack_drive_ff) begin
            state_ff <= psw_pkg::ST_DATA;
          end
        end
        psw_pkg::ST_SKIP: state_ff <= psw_pkg::ST_SKIP;
        default: state_ff <= psw_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      bit_cnt_ff <= 3'h0;
      shift_ff <= 7'h00;
    end else if (start_cond || (scl_fall && ack_drive_ff)) begin
      bit_cnt_ff <= 3'h0;
    end else if (scl_rise && (state_ff == psw_pkg::ST_ADDR || state_ff == psw_pkg::ST_DATA)) begin
      bit_cnt_ff <= bit_cnt_ff + 3'h1;
      shift_ff <= rx_byte[6:0];
    end
  end

  // ****************************************
  // Acknowledge drive
  // ****************************************
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ack_drive_ff <= 1'b0;
    end else if (start_cond || stop_cond) begin
      ack_drive_ff <= 1'b0;
    end else if (scl_fall &&
                 (state_ff == psw_pkg::ST_ADDR_ACK || state_ff == psw_pkg::ST_DATA_ACK)) begin
      ack_drive_ff <= ~ack_drive_ff;
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sda_out <= 1'b0;
      sda_oe_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
      sda_oe_out <= ack_drive_ff;
    end
  end

  // ****************************************
  // Programming registers
  // ****************************************
  logic first_byte_ff;
  logic [1:0] slot_ff;
  logic [1:0] slot;
  logic data_load;
  logic [6:0] upper_pend_ff;
  logic upper_new_ff;
  psw_pkg::psw_ctrl_t ctrl_ff;

  assign data_load = byte_done && (state_ff == psw_pkg::ST_DATA);
  assign slot = first_byte_ff ?
                (rx_byte[psw_pkg::SEL_BIT_POS] ? psw_pkg::SLOT_MODE_REF
                                               : psw_pkg::SLOT_DIV_UPPER) : slot_ff;

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      first_byte_ff <= 1'b0;
      slot_ff <= psw_pkg::SLOT_DIV_UPPER;
    end else if (state_ff == psw_pkg::ST_ADDR_ACK) begin
      first_byte_ff <= 1'b1;
    end else if (data_load) begin
      first_byte_ff <= 1'b0;
      slot_ff <= slot + 2'h1;
    end
  end

  // The upper divider byte is staged until the lower byte, or applied with the old lower byte at a stop
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      upper_pend_ff <= psw_pkg::RST_DIV_RATIO[14:8];
      upper_new_ff <= 1'b0;
      divider_ratio_out <= psw_pkg::RST_DIV_RATIO;
    end else if (data_load && slot == psw_pkg::SLOT_DIV_UPPER) begin
      upper_pend_ff <= rx_byte[6:0];
      upper_new_ff <= 1'b1;
    end else if (data_load && slot == psw_pkg::SLOT_DIV_LOWER) begin
      divider_ratio_out <= {upper_pend_ff, rx_byte};
      upper_new_ff <= 1'b0;
    end else if (stop_cond && upper_new_ff) begin
      divider_ratio_out <= {upper_pend_ff, divider_ratio_out[7:0]};
      upper_new_ff <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ctrl_ff.test_sel <= psw_pkg::RST_TEST_SEL;
      ctrl_ff.refdiv_sel <= psw_pkg::RST_REFDIV_SEL;
      ctrl_ff.pump_sel <= psw_pkg::RST_PUMP_SEL;
    end else if (data_load && slot == psw_pkg::SLOT_MODE_REF) begin
      ctrl_ff.test_sel <= rx_byte[psw_pkg::TEST_MSB:psw_pkg::TEST_LSB];
      ctrl_ff.refdiv_sel <= rx_byte[psw_pkg::REFSEL_MSB:psw_pkg::REFSEL_LSB];
    end else if (data_load && slot == psw_pkg::SLOT_PUMP) begin
      ctrl_ff.pump_sel <= rx_byte[psw_pkg::PUMP_MSB:psw_pkg::PUMP_LSB];
    end
  end

  // ****************************************
  // Reference divider and main divider
  // ****************************************
  logic vco_d_ff;
  logic xtal_d_ff;
  logic [5:0] ref_ratio_ff;
  logic comp_tick;
  logic comp_half;
  logic div_tick;
  logic div_half;

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      vco_d_ff <= 1'b0;
      xtal_d_ff <= 1'b0;
    end else begin
      vco_d_ff <= vco_in;
      xtal_d_ff <= crystal_in;
    end
  end

  // Disallowed encodings keep the last legal ratio
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ref_ratio_ff <= psw_pkg::REF_RATIO_2;
    end else begin
      case (ctrl_ff.refdiv_sel)
        psw_pkg::RS_DIV2: ref_ratio_ff <= psw_pkg::REF_RATIO_2;
        psw_pkg::RS_DIV4: ref_ratio_ff <= psw_pkg::REF_RATIO_4;
        psw_pkg::RS_DIV8: ref_ratio_ff <= psw_pkg::REF_RATIO_8;
        psw_pkg::RS_DIV16: ref_ratio_ff <= psw_pkg::REF_RATIO_16;
        psw_pkg::RS_DIV32: ref_ratio_ff <= psw_pkg::REF_RATIO_32;
        default: ref_ratio_ff <= ref_ratio_ff;
      endcase
    end
  end

  psw_div #(.W(psw_pkg::REF_W)) u_ref_div (
    .ref_clk_in(ref_clk_in),
    .arst_n_in(arst_n_in),
    .edge_in(crystal_in & ~xtal_d_ff),
    .ratio_in(ref_ratio_ff),
    .tick_out(comp_tick),
    .half_out(comp_half)
  );

  psw_div #(.W(psw_pkg::DIV_W)) u_main_div (
    .ref_clk_in(ref_clk_in),
    .arst_n_in(arst_n_in),
    .edge_in(vco_in & ~vco_d_ff),
    .ratio_in(divider_ratio_out),
    .tick_out(div_tick),
    .half_out(div_half)
  );

  // ****************************************
  // Phase/frequency comparator and pump control
  // ****************************************
  logic pfd_up_ff;
  logic pfd_dn_ff;

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pfd_up_ff <= 1'b0;
      pfd_dn_ff <= 1'b0;
    end else if (pfd_up_ff && pfd_dn_ff) begin
      pfd_up_ff <= comp_tick;
      pfd_dn_ff <= div_tick;
    end else begin
      pfd_up_ff <= pfd_up_ff | comp_tick;
      pfd_dn_ff <= pfd_dn_ff | div_tick;
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pump_up_out <= 1'b0;
      pump_dn_out <= 1'b0;
      tuning_release_out <= 1'b1;
      crystal_buffer_out <= 1'b0;
      pump_current_out <= psw_pkg::RST_PUMP_SEL;
      test_mode_out <= psw_pkg::RST_TEST_SEL;
    end else begin
      pump_current_out <= ctrl_ff.pump_sel;
      test_mode_out <= ctrl_ff.test_sel;
      pump_up_out <= pfd_up_ff & ~pfd_dn_ff;
      pump_dn_out <= pfd_dn_ff & ~pfd_up_ff;
      tuning_release_out <= 1'b0;
      crystal_buffer_out <= xtal_d_ff;
      case (ctrl_ff.test_sel)
        psw_pkg::TM_NORMAL_XOFF: crystal_buffer_out <= 1'b0;
        psw_pkg::TM_NORMAL: crystal_buffer_out <= xtal_d_ff;
        psw_pkg::TM_HALF_DIV: crystal_buffer_out <= div_half;
        psw_pkg::TM_DBL_REF: crystal_buffer_out <= comp_half;
        psw_pkg::TM_SINK_INIT, psw_pkg::TM_SINK: begin
          pump_up_out <= 1'b0;
          pump_dn_out <= 1'b1;
          tuning_release_out <= 1'b1;
        end
        psw_pkg::TM_SOURCE: begin
          pump_up_out <= 1'b1;
          pump_dn_out <= 1'b0;
          tuning_release_out <= 1'b1;
        end
        psw_pkg::TM_PUMP_OFF: begin
          pump_up_out <= 1'b0;
          pump_dn_out <= 1'b0;
          tuning_release_out <= 1'b1;
        end
        default: crystal_buffer_out <= xtal_d_ff;
      endcase
    end
  end

endmodule

// *** psw_top_asserts.sv ***
// Property checker for the synthesizer programming port
`timescale 1ns/1ps
module psw_asserts (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  // Watched ports
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe_out,
  input wire logic pump_up_out,
  input wire logic pump_dn_out,
  input wire logic tuning_release_out,
  input wire logic [14:0] divider_ratio_out,
  input wire logic [2:0] test_mode_out
);
  // ****************************************
  // Mode age, so pump checks skip the switch-over
  // ****************************************
  logic [2:0] tm_prev_ff;
  logic [1:0] tm_age_ff;
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tm_prev_ff <= psw_pkg::RST_TEST_SEL;
      tm_age_ff <= 2'h0;
    end else begin
      tm_prev_ff <= test_mode_out;
      if (test_mode_out != tm_prev_ff) tm_age_ff <= 2'h0;
      else if (tm_age_ff != 2'h3) tm_age_ff <= tm_age_ff + 2'h1;
    end
  end
  // ****************************************
  // Properties
  // ****************************************
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!arst_n_in);
  sequence s_ack_on;
    $rose(sda_oe_out);
  endsequence
  sequence s_ack_off;
    ##[1:400] !sda_oe_out;
  endsequence
  a_ack_scl_low: assert property (s_ack_on |-> !scl_in)
    else $error("acknowledge raised while bus clock high");
  a_ack_bounded: assert property (s_ack_on |-> s_ack_off)
    else $error("acknowledge never released");
  a_ack_end_low: assert property ($fell(sda_oe_out) |-> !scl_in)
    else $error("acknowledge released while bus clock high");
  a_sda_only_low: assert property (sda_oe_out |-> !sda_out)
    else $error("data line driven high");
  a_ratio_on_high: assert property ($changed(divider_ratio_out) |-> scl_in || $past(scl_in))
    else $error("divider ratio changed outside a clock high phase");
  a_mode_on_high: assert property ($changed(test_mode_out) |-> scl_in || $past(scl_in))
    else $error("test mode changed outside a clock high phase");
  a_release_mode: assert property (tm_age_ff == 2'h3 |->
    tuning_release_out == (test_mode_out inside {3'h1, 3'h3, 3'h6, 3'h7}))
    else $error("tuning release does not follow test mode");
  a_pump_sink: assert property (tm_age_ff == 2'h3 && test_mode_out inside {3'h1, 3'h3} |->
    pump_dn_out && !pump_up_out)
    else $error("pump not sinking");
  a_pump_source: assert property (tm_age_ff == 2'h3 && test_mode_out == 3'h7 |->
    pump_up_out && !pump_dn_out)
    else $error("pump not sourcing");
  a_pump_off: assert property (tm_age_ff == 2'h3 && test_mode_out == 3'h6 |->
    !pump_up_out && !pump_dn_out)
    else $error("pump not off");
endmodule
bind psw_top psw_asserts u_chk (
  .ref_clk_in(ref_clk_in),
  .arst_n_in(arst_n_in),
  .scl_in(scl_in),
  .sda_out(sda_out),
  .sda_oe_out(sda_oe_out),
  .pump_up_out(pump_up_out),
  .pump_dn_out(pump_dn_out),
  .tuning_release_out(tuning_release_out),
  .divider_ratio_out(divider_ratio_out),
  .test_mode_out(test_mode_out)
);

// *** tb.sv ***
// Self-checking bench for the synthesizer programming port
`timescale 1ns/1ps
module tb;
  typedef struct {
    logic [14:0] ratio;
    logic [2:0] tm;
    logic [2:0] rs;
    logic [1:0] cp;
  } psw_row_t;
  localparam logic [7:0] ADR = {psw_pkg::ADDR_FIXED, 2'h2, psw_pkg::ADDR_DIR_WRITE};
  logic ref_clk_in = 1'h0;
  logic arst_n_in = 1'h0;
  logic scl, sda_low, sda, sda_out, sda_oe_out, up, dn, rel, xbuf, ack, aack;
  logic vco = 1'h0;
  logic xb_d;
  logic [1:0] asel = 2'h2;
  logic xtal = 1'h0;
  logic [1:0] cp;
  logic [14:0] ratio;
  logic [2:0] tm;
  logic [7:0] d [5];
  logic [7:0] bad [3] = '{ADR ^ 8'h10, ADR ^ 8'h04, ADR | 8'h01};
  int mismatches = 0;
  int compares = 0;
  int vco_half = 2;
  int vc = 0;
  int xc = 0;
  int n_up = 0;
  int n_dn = 0;
  int u0, d0, x0;
  int n_xb = 0;
  psw_row_t rows [8] = '{
    '{15'h7fff, 3'h0, 3'h0, 2'h0}, '{15'h0001, 3'h1, 3'h1, 2'h1},
    '{15'h4000, 3'h2, 3'h2, 2'h2}, '{15'h1234, 3'h3, 3'h5, 2'h3},
    '{15'h2aaa, 3'h4, 3'h7, 2'h0}, '{15'h5555, 3'h5, 3'h0, 2'h1},
    '{15'h0100, 3'h6, 3'h1, 2'h2}, '{15'h00ff, 3'h7, 3'h5, 2'h3}};
  // Open-drain line with pull-up
  assign sda = !(sda_low || sda_oe_out);
  always #25 ref_clk_in = ~ref_clk_in;
  // Crystal at a fifth of the clock, oscillator at a set division
  always @(posedge ref_clk_in) begin
    xc <= (xc == 4) ? 0 : xc + 1;
    xtal <= (xc < 2);
    vc <= (vc >= vco_half - 1) ? 0 : vc + 1;
    if (vc >= vco_half - 1) vco <= ~vco;
    n_up <= n_up + int'(up === 1'h1);
    n_dn <= n_dn + int'(dn === 1'h1);
    xb_d <= xbuf;
    n_xb <= n_xb + int'(xbuf !== xb_d);
  end
  psw_top uut (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_out(sda_oe_out), .addr_select_hi_in(asel[1]),
    .addr_select_lo_in(asel[0]), .vco_in(vco), .crystal_in(xtal), .pump_up_out(up),
    .pump_dn_out(dn), .pump_current_out(cp), .tuning_release_out(rel),
    .crystal_buffer_out(xbuf), .divider_ratio_out(ratio), .test_mode_out(tm));
  psw_host host (.ref_clk_in(ref_clk_in), .sda_in(sda), .scl_out(scl), .sda_low_out(sda_low));
  task automatic chk(input string nm, input logic [14:0] e, input logic [14:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic frame(input logic [7:0] a, input int n);
    host.send_start();
    host.put_byte(a, aack);
    for (int i = 0; i < n; i++) host.put_byte(d[i], ack);
    host.send_stop();
    #1;
  endtask
  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (80000) @(posedge ref_clk_in);
    mismatches++;
    stop_test();
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (15) @(posedge ref_clk_in);
    #1;
    chk("reset ratio", 15'h0001, ratio);
    chk("reset test", 15'h0001, 15'(tm));
    chk("reset release", 15'h0001, 15'(rel));
    @(posedge ref_clk_in);
    arst_n_in <= 1'h1;
    repeat (2) @(posedge ref_clk_in);
    $display("test reset done");
    foreach (rows[i]) begin
      d[0] = {1'h0, rows[i].ratio[14:8]};
      d[1] = rows[i].ratio[7:0];
      d[2] = {1'h1, rows[i].tm, rows[i].rs, 1'h1};
      d[3] = {rows[i].cp, 6'h3f};
      frame(ADR, 4);
      chk("address ack", 15'h0001, 15'(aack));
      chk("ratio", rows[i].ratio, ratio);
      chk("test", 15'(rows[i].tm), 15'(tm));
      chk("pump", 15'(rows[i].cp), 15'(cp));
      chk("release", 15'(rows[i].tm inside {3'h1, 3'h3, 3'h6, 3'h7}), 15'(rel));
      chk("data ack", 15'h0001, 15'(ack));
      x0 = n_xb;
      repeat (40) @(posedge ref_clk_in);
      // At this row's ratio the halved divider output is too slow to toggle in the window
      chk("crystal out", 15'(!(rows[i].tm inside {3'h0, 3'h2})), 15'(n_xb != x0));
      $display("test row %0d done", i);
    end
    d[0] = 8'h7f;
    d[1] = 8'h00;
    foreach (bad[i]) begin
      frame(bad[i], 2);
      chk("refused ack", 15'h0000, 15'(aack));
      chk("refused ratio", 15'h00ff, ratio);
    end
    @(posedge ref_clk_in);
    asel <= 2'h1;
    frame(ADR, 2);
    chk("strap refused ack", 15'h0000, 15'(aack));
    chk("strap refused ratio", 15'h00ff, ratio);
    d[0] = 8'hc8;
    frame(ADR ^ 8'h06, 1);
    chk("strap ack", 15'h0001, 15'(aack));
    chk("strap test", 15'h0004, 15'(tm));
    @(posedge ref_clk_in);
    asel <= 2'h2;
    $display("test refused addresses done");
    host.send_start();
    host.put_byte(ADR, aack);
    host.put_byte(8'h12, ack);
    #1;
    chk("ratio before stop", 15'h00ff, ratio);
    host.send_stop();
    #1;
    chk("ratio at stop", 15'h12ff, ratio);
    $display("test upper only done");
    d[0] = 8'hf8;
    frame(ADR, 1);
    chk("control first test", 15'h0007, 15'(tm));
    chk("control first ratio", 15'h12ff, ratio);
    $display("test control first done");
    host.q_len = 9;
    d = '{8'h00, 8'h20, 8'hc0, 8'h40, 8'h03};
    frame(ADR, 5);
    host.q_len = 4;
    chk("wrap ratio", 15'h0320, ratio);
    chk("wrap test", 15'h0004, 15'(tm));
    chk("wrap pump", 15'h0001, 15'(cp));
    $display("test wrap slow done");
    host.send_start();
    host.put_byte(ADR, aack);
    host.put_byte(8'ha0, ack);
    host.send_start();
    host.put_byte(ADR, aack);
    host.put_byte(8'hd0, ack);
    host.send_stop();
    #1;
    chk("restart ack", 15'h0001, 15'(aack));
    chk("restart test", 15'h0005, 15'(tm));
    $display("test restart done");
    // Slow oscillator, ratio 16: divided rate under the 2 MHz comparison
    d = '{8'h00, 8'h10, 8'hc0, 8'h00, 8'h00};
    frame(ADR, 3);
    repeat (200) @(posedge ref_clk_in);
    u0 = n_up;
    d0 = n_dn;
    repeat (2000) @(posedge ref_clk_in);
    chk("pump raises", 15'h0001, 15'((n_up - u0) > (n_dn - d0)));
    // Reference ratio 32 puts the comparison under the divided rate
    d[0] = 8'hce;
    frame(ADR, 1);
    repeat (400) @(posedge ref_clk_in);
    u0 = n_up;
    d0 = n_dn;
    repeat (2000) @(posedge ref_clk_in);
    chk("pump lowers", 15'h0001, 15'((n_dn - d0) > (n_up - u0)));
    $display("test comparator done");
    @(posedge ref_clk_in);
    arst_n_in <= 1'h0;
    repeat (2) @(posedge ref_clk_in);
    #1;
    chk("rerun ratio", 15'h0001, ratio);
    chk("rerun test", 15'h0001, 15'(tm));
    chk("rerun release", 15'h0001, 15'(rel));
    @(posedge ref_clk_in);
    arst_n_in <= 1'h1;
    repeat (2) @(posedge ref_clk_in);
    $display("test mid reset done");
    stop_test();
  end
endmodule
